// *** core/otmr_timer.sv ***
// One timer channel in one-shot or pulse width modulation mode.
// Assumes all inputs are synchronous to clk and that wrStrobe and oneShotStart are one-cycle pulses.
`timescale 1ns/10ps
module otmr_timer
  import otmr_pkg::*;
(
  input  wire logic        clk,               // System clock, 100 MHz
  input  wire logic        rst_b,             // Synchronous reset, active low
  input  wire otmr_mode_t  modeSel,           // Operating mode
  input  wire otmr_src_t   srcSel,            // Count source
  input  wire otmr_trg_t   trigSel,           // Hardware trigger source
  input  wire logic        pwm8Sel,           // PWM width: 1 = 8-bit, 0 = 16-bit
  input  wire logic        pulseOutSel,       // One-shot: 1 = pin carries pulse
  input  wire logic        countStart,        // Count start flag
  input  wire logic        oneShotStart,      // One-shot start flag write, pulse
  input  wire logic        wrStrobe,          // Counter register write, pulse
  input  wire logic [15:0] wrData,            // Counter register write data
  input  wire logic        timerTriggerInPin, // Trigger input pin level
  input  wire logic        otherTimerOvf,     // Overflow pulse of another timer
  input  wire logic        subclockDiv32,     // Sub-clock divided by 32, enable
  output logic      [15:0] rdData,            // Counter register read data
  output logic             timerPulseOutPin,  // Pulse output pin level
  output logic             pulsePinSel,       // 1 = output pin driven by the timer
  output logic             irqPulse,          // Interrupt request, one cycle
  output logic             running            // Counting in progress
);

  // Channel state
  typedef struct packed {
    logic        running;  // Counting in progress
    logic        pulse;    // Pulse output level
    logic        irq;      // Interrupt request
    logic        pinSel;   // Output pin function
    logic        prevPin;  // Trigger pin level last cycle
    logic [15:0] reload;   // Reload register
    logic [15:0] cnt;      // Down counter
    logic [15:0] cyc;      // PWM cycle counter
    logic [7:0]  pre;      // 8-bit PWM unit prescaler
    logic [7:0]  mVal;     // Prescale value in use this period
  } otmr_state_t;

  otmr_state_t st_reg;     // Current state
  otmr_state_t st_next;    // Next state
  logic        countTick;  // Selected count clock enable
  logic        hwTrig;     // Hardware trigger event
  logic        trigEvt;    // Any one-shot trigger event

  ////////////////////////////////////////////////////////////////////////////////
  // Count clock selection
  otmr_prescale otmr_prescale_i
  (
    .clk           (clk),
    .rst_b         (rst_b),
    .srcSel        (srcSel),
    .subclockDiv32 (subclockDiv32),
    .countTick     (countTick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Trigger decode
  always_comb
  begin
    case (trigSel)
      OTMR_TRG_PIN_FALL: hwTrig = st_reg.prevPin && !timerTriggerInPin;
      OTMR_TRG_PIN_RISE: hwTrig = !st_reg.prevPin && timerTriggerInPin;
      OTMR_TRG_OVF:      hwTrig = otherTimerOvf;
      default:           hwTrig = 1'b0;  // Pin is a plain port
    endcase
    trigEvt = hwTrig || oneShotStart;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    logic [15:0] hiVal;  // High-phase length of a new PWM period
    logic        unit;   // PWM unit tick
    hiVal   = pwm8Sel ? {OTMR_BYTE_ZERO, st_reg.reload[15:8]} : st_reg.reload;
    unit    = countTick && (!pwm8Sel || st_reg.pre == OTMR_BYTE_ZERO);
    st_next = st_reg;
    st_next.irq     = 1'b0;
    st_next.prevPin = timerTriggerInPin;
    st_next.pinSel  = (modeSel == OTMR_MODE_PWM) || pulseOutSel;
    // Software write: counter follows only while stopped
    if (wrStrobe)
    begin
      st_next.reload = wrData;
      if (!st_reg.running)
      begin
        st_next.cnt = wrData;
      end
    end
    if (!countStart)
    begin
      // Clearing the flag stops either mode
      st_next.running = 1'b0;
      st_next.pulse   = 1'b0;
    end
    else if (modeSel == OTMR_MODE_ONESHOT)
    begin
      if (trigEvt)
      begin
        // Start, or restart from the reload value while counting
        st_next.running = 1'b1;
        st_next.cnt     = wrStrobe ? wrData : st_reg.reload;
        st_next.pulse   = pulseOutSel;
      end
      else if (st_reg.running && countTick)
      begin
        if (st_reg.cnt <= OTMR_CNT_ONE)
        begin
          // Reaching zero: reload, stop, request interrupt
          st_next.cnt     = st_reg.reload;
          st_next.running = 1'b0;
          st_next.pulse   = 1'b0;
          st_next.irq     = 1'b1;
        end
        else
        begin
          st_next.cnt = st_reg.cnt - OTMR_CNT_ONE;
        end
      end
    end
    else if (!st_reg.running ? (trigSel == OTMR_TRG_SW || hwTrig) : unit && st_reg.cyc <= OTMR_CNT_ONE)
    begin
      // New PWM period; triggers play no part once running
      st_next.running = 1'b1;
      st_next.cnt     = hiVal;
      st_next.cyc     = pwm8Sel ? OTMR_PWM8_CYCLE : OTMR_PWM16_CYCLE;
      st_next.mVal    = st_reg.reload[7:0];
      st_next.pre     = st_reg.reload[7:0];
      st_next.pulse   = (hiVal != OTMR_CNT_ZERO);
    end
    else if (st_reg.running && countTick)
    begin
      // Unit prescaler, 8-bit width only
      if (pwm8Sel)
      begin
        st_next.pre = unit ? st_reg.mVal : st_reg.pre - 8'h01;
      end
      if (unit)
      begin
        st_next.cyc = st_reg.cyc - OTMR_CNT_ONE;
        if (st_reg.cnt != OTMR_CNT_ZERO)
        begin
          st_next.cnt = st_reg.cnt - OTMR_CNT_ONE;
          if (st_reg.cnt == OTMR_CNT_ONE)
          begin
            // High phase ends: pulse falls and interrupt raised
            st_next.pulse = 1'b0;
            st_next.irq   = 1'b1;
          end
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      // Edge detector follows the pin through reset, so no false edge after release
      st_reg <= '{running: 1'b0, pulse: 1'b0, irq: 1'b0, pinSel: 1'b0, prevPin: timerTriggerInPin,
                  reload: OTMR_RELOAD_RST, cnt: OTMR_CNT_ZERO, cyc: OTMR_CNT_ZERO,
                  pre: OTMR_BYTE_ZERO, mVal: OTMR_BYTE_ZERO};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, all from the state register
  assign rdData           = st_reg.reload;
  assign timerPulseOutPin = st_reg.pulse;
  assign pulsePinSel      = st_reg.pinSel;
  assign irqPulse         = st_reg.irq;
  assign running          = st_reg.running;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  logic osMode;  // One-shot mode held
  assign osMode = (modeSel == OTMR_MODE_ONESHOT);

  AST_OS_END: assert property (countStart && osMode && st_reg.running && countTick && !trigEvt
                               && st_reg.cnt == OTMR_CNT_ONE |=> !running && irqPulse && st_reg.cnt == $past(st_reg.reload))
    else $error("one-shot did not stop and interrupt at zero");
  AST_OS_RETRIG: assert property (countStart && osMode && st_reg.running && trigEvt && !wrStrobe
                                  |=> running && st_reg.cnt == $past(st_reg.reload))
    else $error("trigger while counting did not restart from reload");
  AST_OS_START: assert property (countStart && osMode && !st_reg.running && trigEvt
                                 |=> running)
    else $error("one-shot trigger did not start counting");
  AST_FLAG_STOP: assert property (!countStart |=> !running && !timerPulseOutPin)
    else $error("clearing count start flag did not stop");
  AST_WR_IDLE: assert property (wrStrobe && !st_reg.running && (osMode || !countStart)
                                |=> st_reg.cnt == $past(wrData) && rdData == $past(wrData))
    else $error("write while stopped did not load counter");
  AST_WR_RUN: assert property (wrStrobe && countStart && osMode && st_reg.running && !trigEvt
                               && st_reg.cnt > OTMR_CNT_ONE
                               |=> running && st_reg.cnt == $past(st_reg.cnt) - {15'h0000, $past(countTick)}
                               && rdData == $past(wrData))
    else $error("write while counting disturbed counter");
  AST_PWM_NOTRIG: assert property (countStart && !osMode && st_reg.running && hwTrig
                                   && st_reg.cyc > OTMR_CNT_ONE
                                   |=> running && st_reg.cnt <= $past(st_reg.cnt) && st_reg.cyc <= $past(st_reg.cyc))
    else $error("trigger disturbed running PWM");
  AST_PWM_IRQ: assert property (irqPulse && !osMode |-> $past(timerPulseOutPin) && !timerPulseOutPin)
    else $error("PWM interrupt not at falling pulse");
  AST_PWM8_CYC: assert property ($rose(timerPulseOutPin) && !osMode && pwm8Sel
                                 |-> st_reg.cyc == OTMR_PWM8_CYCLE && st_reg.cnt == $past(st_reg.reload) >> 8)
    else $error("8-bit PWM period not loaded");
  AST_PWM_PIN: assert property (!osMode ##1 !osMode |-> pulsePinSel)
    else $error("PWM output pin not dedicated");

  COV_OS_DONE:  cover property (osMode && irqPulse);
  COV_OS_RETRG: cover property (osMode && st_reg.running && hwTrig ##1 running);
  COV_PWM16:    cover property (!osMode && !pwm8Sel && irqPulse);
  COV_PWM8:     cover property (!osMode && pwm8Sel && irqPulse);

endmodule // otmr_timer

// *** core/otmr_pkg.sv ***
// Package for the one-shot / PWM timer channel: mode encodings and counter constants.
// Assumes one 100 MHz clock; every slower count rate arrives as a one-cycle enable.
package otmr_pkg;

  // Counter width and handy counter values
  localparam int          OTMR_CNT_W      = 16;
  localparam logic [15:0] OTMR_CNT_ZERO   = 16'h0000;
  localparam logic [15:0] OTMR_CNT_ONE    = 16'h0001;
  localparam logic [15:0] OTMR_RELOAD_RST = 16'h0000;

  // PWM cycle lengths in units: 2^16-1 source periods, or 2^8-1 prescaled units
  localparam logic [15:0] OTMR_PWM16_CYCLE = 16'hffff;
  localparam logic [15:0] OTMR_PWM8_CYCLE  = 16'h00ff;
  localparam logic [7:0]  OTMR_BYTE_ZERO   = 8'h00;

  // Prescaler terminal counts for divide-by-8 and divide-by-32
  localparam logic [2:0]  OTMR_DIV8_LAST  = 3'h7;
  localparam logic [4:0]  OTMR_DIV32_LAST = 5'h1f;
  localparam logic [4:0]  OTMR_DIV_ONE    = 5'h01;
  localparam logic [4:0]  OTMR_DIV_RST    = 5'h00;

  // Operating mode
  typedef enum logic [0:0] {
    OTMR_MODE_ONESHOT = 1'b0,
    OTMR_MODE_PWM     = 1'b1
  } otmr_mode_t;

  // Count source for the selected count clock
  typedef enum logic [1:0] {
    OTMR_SRC_DIV1  = 2'b00,
    OTMR_SRC_DIV8  = 2'b01,
    OTMR_SRC_DIV32 = 2'b10,
    OTMR_SRC_SUB32 = 2'b11
  } otmr_src_t;

  // Hardware trigger source
  typedef enum logic [1:0] {
    OTMR_TRG_SW       = 2'b00,
    OTMR_TRG_PIN_FALL = 2'b01,
    OTMR_TRG_PIN_RISE = 2'b10,
    OTMR_TRG_OVF      = 2'b11
  } otmr_trg_t;

endpackage

// *** core/otmr_prescale.sv ***
// Count clock selector: turns the system clock into one-cycle count enables.
// Assumes subclockDiv32 is already a one-cycle enable synchronous to clk.
`timescale 1ns/10ps
module otmr_prescale
  import otmr_pkg::*;
(
  input  wire logic      clk,            // System clock
  input  wire logic      rst_b,          // Synchronous reset, active low
  input  wire otmr_src_t srcSel,         // Count source choice
  input  wire logic      subclockDiv32,  // Sub-clock divided by 32, one-cycle enable
  output logic           countTick       // Selected count clock enable, registered
);

  // Divider state
  typedef struct packed {
    logic [4:0] div;   // Free-running divider
    logic       tick;  // Registered enable
  } otmr_pre_t;

  otmr_pre_t st_reg;   // Current state
  otmr_pre_t st_next;  // Next state

  ////////////////////////////////////////////////////////////////////////////////
  // Divider and source multiplexer
  always_comb
  begin
    st_next     = st_reg;
    st_next.div = st_reg.div + OTMR_DIV_ONE;
    case (srcSel)
      OTMR_SRC_DIV1:  st_next.tick = 1'b1;                              // Every cycle
      OTMR_SRC_DIV8:  st_next.tick = (st_reg.div[2:0] == OTMR_DIV8_LAST);  // One in eight
      OTMR_SRC_DIV32: st_next.tick = (st_reg.div == OTMR_DIV32_LAST);      // One in 32
      default:        st_next.tick = subclockDiv32;                     // Sub-clock rate
    endcase
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      st_reg <= '{div: OTMR_DIV_RST, tick: 1'b0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign countTick = st_reg.tick;

endmodule // otmr_prescale

// *** verif/otmr_partner.sv ***
// Far-side model: trigger pin source, neighbour timer overflow and sub-clock/32 enable.
// Assumes trigReq and ovfReq come from the bench as one-cycle pulses synchronous to clk.
`timescale 1ns/10ps
module otmr_partner
(
  input  wire logic clk,      // System clock
  input  wire logic rst_b,    // Synchronous reset, active low
  input  wire logic trigReq,  // Ask for one low pulse on the trigger pin
  input  wire logic ovfReq,   // Ask for one overflow pulse
  output logic      trigPin,  // Trigger pin, pulled up when idle
  output logic      ovfPulse, // Overflow of another timer, one cycle
  output logic      subTick   // Sub-clock divided by 32, one cycle
);
  logic [2:0] lowCnt;         // Cycles left with the pin held low
  logic [4:0] subCnt;         // Free-running sub-clock divider

  ////////////////////////////////////////////////////////////////////////
  // All far-side lines change just after the rising edge
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      trigPin  <= 1'b1;
      lowCnt   <= 3'h0;
      ovfPulse <= 1'b0;
      subCnt   <= 5'h00;
      subTick  <= 1'b0;
    end
    else
    begin
      ovfPulse <= ovfReq;
      subCnt   <= subCnt + 5'h01;
      subTick  <= (subCnt == 5'h1f);
      if (trigReq)
        lowCnt <= 3'h4;
      else if (lowCnt != 3'h0)
        lowCnt <= lowCnt - 3'h1;
      trigPin  <= ~(trigReq | (lowCnt > 3'h1));
    end
  end
endmodule // otmr_partner

// *** verif/oneshot_pwm_timer_tb.sv ***
// Self-checking bench for the one-shot / PWM timer channel.
// Assumes the partner model on the far side; inputs change at the falling edge.
`timescale 1ns/10ps
module oneshot_pwm_timer_tb;
  import otmr_pkg::*;
  logic clk = 0, rst_b = 0, pwm8Sel = 0, pulseOutSel = 1, countStart = 0, oneShotStart = 0;
  logic wrStrobe = 0, trigReq = 0, ovfReq = 0, pin, ovf, sub, pulseOut, pinSel, irq, running;
  logic [15:0] wrData = 16'h0000, rdData;
  otmr_mode_t modeSel = OTMR_MODE_ONESHOT;
  otmr_src_t  srcSel  = OTMR_SRC_DIV1;
  otmr_trg_t  trigSel = OTMR_TRG_SW;
  int fails = 0, comparisons = 0, cycleCount = 0, w, lo;
  logic irqSeen;
  otmr_src_t srcList [3] = '{OTMR_SRC_DIV8, OTMR_SRC_DIV32, OTMR_SRC_SUB32};

  always #5 clk = ~clk;
  otmr_partner otmr_partner_i (.clk(clk), .rst_b(rst_b), .trigReq(trigReq), .ovfReq(ovfReq),
    .trigPin(pin), .ovfPulse(ovf), .subTick(sub));
  otmr_timer otmr_timer_i (.clk(clk), .rst_b(rst_b), .modeSel(modeSel), .srcSel(srcSel),
    .trigSel(trigSel), .pwm8Sel(pwm8Sel), .pulseOutSel(pulseOutSel), .countStart(countStart),
    .oneShotStart(oneShotStart), .wrStrobe(wrStrobe), .wrData(wrData), .timerTriggerInPin(pin),
    .otherTimerOvf(ovf), .subclockDiv32(sub), .rdData(rdData), .timerPulseOutPin(pulseOut),
    .pulsePinSel(pinSel), .irqPulse(irq), .running(running));

  ////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and hang guard
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %0d seen %0d", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycleCount++;
    if (cycleCount == 95000)
    begin
      fails++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Access tasks, all entered and left at a falling edge
  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(logic [15:0] d);
    wrStrobe = 1'b1;
    wrData   = d;
    tick(1);
    wrStrobe = 1'b0;
  endtask
  task automatic pulse_sw();
    oneShotStart = 1'b1;
    tick(1);
    oneShotStart = 1'b0;
  endtask
  task automatic req(input bit useOvf);
    if (useOvf) ovfReq = 1'b1; else trigReq = 1'b1;
    tick(1);
    ovfReq  = 1'b0;
    trigReq = 1'b0;
  endtask
  // High width of the next output pulse, and irq at its fall
  task automatic measure(output int hi, output logic irqAtFall);
    int k;
    hi = 0;
    k  = 0;
    while (pulseOut !== 1'b1 && k < 3000) begin tick(1); k++; end
    while (pulseOut === 1'b1 && hi < 70000) begin tick(1); hi++; end
    irqAtFall = irq;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    tick(6);
    rst_b = 1'b1;
    check("resetRunning", {pulseOut, irq, running}, 0);
    countStart = 1'b1;
    wr(16'h0003);
    tick(1);
    check("readBack", rdData, 16'h0003);
    pulseOutSel = 1'b0;                                  // Pin as plain port first
    pulse_sw();
    tick(1);
    check("portMode", {running, pinSel, pulseOut}, 3'h4);
    tick(4);
    pulseOutSel = 1'b1;
    pulse_sw();
    measure(w, irqSeen);
    check("oneShotWidth", w, 3);
    check("oneShotIrq", {irqSeen, running}, 2'h2);
    wr(16'h0014);                                        // Stopped: 20 loads now
    trigSel = OTMR_TRG_PIN_FALL;
    req(0);
    fork
      measure(w, irqSeen);
      begin tick(10); req(0); tick(2); wr(16'h0005); end  // Retrigger, then reload-only write
    join
    check("retriggerWidth", w, 31);
    trigSel = OTMR_TRG_SW;
    pulse_sw();
    measure(w, irqSeen);
    check("newReload", w, 5);
    wr(16'h0014);
    pulse_sw();
    tick(5);
    countStart = 1'b0;
    tick(2);
    check("flagStop", {running, pulseOut}, 0);
    countStart = 1'b1;
    wr(16'h0002);
    foreach (srcList[i])
    begin
      srcSel = srcList[i];
      pulse_sw();
      measure(w, irqSeen);
      check("srcWidth", 32'(w > (i == 0 ? 8 : 32) && w <= (i == 0 ? 16 : 64)), 1);
      tick(3);
    end
    srcSel = OTMR_SRC_DIV1;
    // 8-bit PWM started by overflow: n=2, m=1
    countStart = 1'b0;
    modeSel = OTMR_MODE_PWM;
    pwm8Sel = 1'b1;
    trigSel = OTMR_TRG_OVF;
    wr(16'h0201);
    countStart = 1'b1;
    tick(3);
    check("waitTrigger", running, 0);
    req(1);
    measure(w, irqSeen);
    check("pwm8High", w, 4);
    check("pwm8Irq", irqSeen, 1);
    lo = 0;
    fork
      while (pulseOut !== 1'b1 && lo < 3000) begin tick(1); lo++; end
      begin tick(20); req(1); end                        // Ignored while running
    join
    check("pwm8Low", lo, 506);
    countStart = 1'b0;
    tick(2);
    check("pwmStop", {running, pulseOut}, 0);
    // 16-bit PWM started by the flag: n=3
    pwm8Sel = 1'b0;
    trigSel = OTMR_TRG_SW;
    wr(16'h0003);
    countStart = 1'b1;
    measure(w, irqSeen);
    check("pwm16High", w, 3);
    lo = 0;
    while (pulseOut !== 1'b1 && lo < 70000) begin tick(1); lo++; end
    check("pwm16Low", lo, 65532);
    check("pwmPin", pinSel, 1);
    countStart = 1'b0;
    tick(2);
    check("pwm16Stop", running, 0);
    complete_run();
  end
endmodule // oneshot_pwm_timer_tb
